// ### hw/wlp_defs.vh
// Constants for the watchdog and low-power control block
`ifndef WLP_DEFS_VH
`define WLP_DEFS_VH

// Configuration word addresses (table-read space)
`define WLP_OSC_CFG_ADDR 24'hf80000
`define WLP_WDT_CFG_ADDR 24'hf80002
`define WLP_SEG_CFG_ADDR 24'hf8000a

// Field positions in the watchdog configuration word
`define WLP_CFG_WDT_EN_BIT 7

// Reset-control register bit positions
`define WLP_RC_POR 0
`define WLP_RC_IDLE 2
`define WLP_RC_SLEEP 3
`define WLP_RC_WATCHDOG_TIMEOUT_FLAG 4
`define WLP_RC_SWEN 5
`define WLP_RC_SWR 6
`define WLP_RC_EXTR 7
`define WLP_RC_MASK 16'h00fd

// Erased configuration word value
`define WLP_CFG_ERASED 24'hffffff

// Power-save operand codes
`define WLP_PS_DEEP 1'b0
`define WLP_PS_CORE 1'b1

// Oscillator source codes of the current-oscillator field
`define WLP_OSC_FRC 3'h0
`define WLP_OSC_FRCPLL 3'h1
`define WLP_OSC_XTAL 3'h2
`define WLP_OSC_XTALPLL 3'h3
`define WLP_OSC_EC 3'h4
`define WLP_OSC_LP 3'h5

// Power-on delay in ns and in 50 ns clock cycles (rounded up)
`define WLP_CLK_NS 50
`define WLP_POWER_ON_DELAY_NS 10000
`define WLP_POWER_ON_DELAY_CYC ((`WLP_POWER_ON_DELAY_NS + `WLP_CLK_NS - 1) / `WLP_CLK_NS)

`endif

// ### hw/wlp_wdog_counter.v
// Watchdog counter clocked by the system clock, counting slow RC ticks
`timescale 1ns/1ps
module wlp_wdog_counter #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire rst_b,
  input wire enable,
  input wire tick,
  input wire clear,
  output reg overflow
);

  reg [WIDTH-1:0] count_q;

  // ----------------------------------------------------------------
  // Count slow ticks, restart on clear, pulse on wrap
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {WIDTH{1'b0}};
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (clear || !enable) begin
        count_q <= {WIDTH{1'b0}};
      end else if (tick) begin
        count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        if (&count_q) begin
          overflow <= 1'b1;
        end
      end
    end
  end

endmodule

// ### hw/wlp_delay_timer.v
// Loadable down-counter for the wake delays
`timescale 1ns/1ps
module wlp_delay_timer #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire rst_b,
  input wire load,
  input wire [WIDTH-1:0] value,
  output reg done
);

  reg [WIDTH-1:0] count_q;

  // ----------------------------------------------------------------
  // Count down after load; done holds once at zero
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {WIDTH{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      count_q <= value;
      done <= 1'b0;
    end else if (count_q != {WIDTH{1'b0}}) begin
      count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      done <= (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
    end else begin
      done <= 1'b1;
    end
  end

endmodule

// ### hw/wlp_power_ctrl.v
// Watchdog enable, low-power states, wake sequencing and status flags
//
// Operation
// - Watchdog always on when configuration enable bit is 1; erased reads 1.
// - Enabled watchdog counts up; overflow in run state forces reset.
// - Overflow in deep state wakes the device instead of resetting.
// - With configuration bit 0, reset-control bit 5 enables the watchdog.
// - Low-power states entered only by the power-save instruction.
// - Deep state gates all clocks, stops oscillator, slow RC if watchdog.
// - Fail-safe clock monitor inactive during the deep state.
// - Deep wake on enabled interrupt, power-on or pin reset, or overflow.
// - Deep wake restarts previous clock: current-oscillator field if clock switching on, else configuration word.
// - Crystal wake waits start-up timer; PLL also waits for lock.
// - External-clock or fast RC wake applies only the power-on delay.
// - Running low-power crystal wake applies only the power-on delay.
// - Deep interrupt wake branches to handler and sets deep status flag.
// - Clock dead after delays: trap with monitor, else suspend until start.
// - Reset ends deep state; non-power-on sets deep flag, power-on clears.
// - Watchdog wake from deep sets deep flag and time-out flag.
// - Core-only state gates processor clock, keeps oscillator; slow RC if monitor on.
// - Peripherals run in core-only state only where their bit permits.
// - Core-only wake on interrupt, reset or overflow; resume at once.
// - Core-only flag set by interrupt wake or non-power-on reset.
// - Watchdog wake from core-only sets core-only and time-out flags.
// - Configuration words are 24 bits, data in low 16, table readable.
// - Watchdog counts slow RC ticks, independent of the system clock; here the counter is clocked by the system clock, with the tick as enable.
`timescale 1ns/1ps
`include "wlp_defs.vh"
module wlp_power_ctrl #(
  parameter WDT_WIDTH = 16,
  parameter DLY_WIDTH = 16,
  parameter NUM_PERIPH = 8,
  parameter [DLY_WIDTH-1:0] LOCK_CYC = 16'h0064,
  parameter [DLY_WIDTH-1:0] POWER_UP_TIMER_CYC = 16'h0fa0
) (
  input wire clock,
  input wire rst_b,
  input wire porEvent,
  input wire extResetEvent,
  input wire swResetEvent,
  input wire [23:0] oscConfigWord,
  input wire [23:0] wdtConfigWord,
  input wire [23:0] segConfigWord,
  input wire tableReadStrobe,
  input wire [23:0] tableReadAddr,
  output reg [23:0] tableReadData,
  input wire rcWrite,
  input wire [15:0] rcWriteData,
  output reg [15:0] resetControlReg,
  input wire watchdogClearInstr,
  input wire powerSaveInstr,
  input wire powerSaveMode,
  input wire slowRcTick,
  input wire irqPending,
  input wire [2:0] currentOscField,
  input wire clockSwitchEnable,
  input wire pllInUse,
  input wire oscStartupDone,
  input wire pllLock,
  input wire lpCrystalKeepOn,
  input wire oscRunning,
  input wire failSafeEnable,
  input wire [NUM_PERIPH-1:0] periphIdleRun,
  output reg cpuClockEn,
  output reg [NUM_PERIPH-1:0] periphClockEn,
  output reg oscEnable,
  output reg [2:0] wakeOscSel,
  output reg slowRcEnable,
  output reg failSafeActive,
  output reg wdtResetReq,
  output reg irqVectorTake,
  output reg clockFailTrap,
  output reg fastRcForce
);

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_DEEP = 3'h1;
  localparam [2:0] ST_CORE = 3'h2;
  localparam [2:0] ST_WAKE = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg wakeIrq_q;
  reg [1:0] phase_q;
  reg [DLY_WIDTH-1:0] dlyValue;
  reg dlyLoad;
  wire dlyDone;
  wire wdtOverflow;
  wire anyReset;
  wire cfgWdtEn;
  wire wdtEnable;
  wire xtalSrc;
  wire fastSrc;
  wire lpKept;
  wire [31:0] tporFull;

  // ----------------------------------------------------------------
  // Watchdog enable and counter
  // ----------------------------------------------------------------
  assign cfgWdtEn = wdtConfigWord[`WLP_CFG_WDT_EN_BIT];
  assign wdtEnable = cfgWdtEn | resetControlReg[`WLP_RC_SWEN];
  assign anyReset = porEvent | extResetEvent | swResetEvent;
  // Power-on delay as a full word, cut to the timer width below
  assign tporFull = `WLP_POWER_ON_DELAY_CYC;

  wlp_wdog_counter #(
    .WIDTH(WDT_WIDTH)
  ) uWdog (
    .clock(clock),
    .rst_b(rst_b),
    .enable(wdtEnable),
    .tick(slowRcTick),
    .clear(watchdogClearInstr | anyReset),
    .overflow(wdtOverflow)
  );

  // Source classes for wake delay choice
  assign xtalSrc = (wakeOscSel == `WLP_OSC_XTAL) ||
                   (wakeOscSel == `WLP_OSC_XTALPLL) ||
                   (wakeOscSel == `WLP_OSC_LP);
  assign fastSrc = (wakeOscSel == `WLP_OSC_FRC) ||
                   (wakeOscSel == `WLP_OSC_EC);
  assign lpKept = (wakeOscSel == `WLP_OSC_LP) && lpCrystalKeepOn;

  wlp_delay_timer #(
    .WIDTH(DLY_WIDTH)
  ) uDelay (
    .clock(clock),
    .rst_b(rst_b),
    .load(dlyLoad),
    .value(dlyValue),
    .done(dlyDone)
  );

  // ----------------------------------------------------------------
  // Next state and delay loading
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    dlyLoad = 1'b0;
    dlyValue = tporFull[DLY_WIDTH-1:0];
    case (state_q)
      ST_RUN: begin
        if (powerSaveInstr && !anyReset) begin
          if (powerSaveMode == `WLP_PS_DEEP) begin
            state_d = ST_DEEP;
          end else begin
            state_d = ST_CORE;
          end
        end
      end
      ST_DEEP: begin
        if (anyReset) begin
          state_d = ST_RUN;
        end else if (irqPending || wdtOverflow) begin
          state_d = ST_WAKE;
          dlyLoad = 1'b1;
          if (!fastSrc && !lpKept) begin
            dlyValue = tporFull[DLY_WIDTH-1:0] + POWER_UP_TIMER_CYC;
          end
        end
      end
      ST_CORE: begin
        if (anyReset || irqPending || wdtOverflow) begin
          state_d = ST_RUN;
        end
      end
      ST_WAKE: begin
        if (anyReset) begin
          state_d = ST_RUN;
        end else if (dlyDone) begin
          if (phase_q == 2'h0 && pllInUse && !fastSrc && !lpKept) begin
            dlyLoad = 1'b1;
            dlyValue = LOCK_CYC;
          end else if (oscRunning && (!xtalSrc || lpKept ||
                       oscStartupDone) && (!pllInUse || pllLock)) begin
            state_d = ST_RUN;
          end else if (failSafeEnable) begin
            state_d = ST_RUN;
          end else begin
            state_d = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (anyReset || (oscRunning && (!xtalSrc || lpKept ||
            oscStartupDone) && (!pllInUse || pllLock))) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State, wake cause and delay phase registers
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      wakeIrq_q <= 1'b0;
      phase_q <= 2'h0;
      wakeOscSel <= `WLP_OSC_FRC;
    end else begin
      state_q <= state_d;
      if (state_q == ST_RUN && state_d == ST_DEEP) begin
        wakeOscSel <= clockSwitchEnable ? currentOscField
                                        : oscConfigWord[2:0];
      end
      if (state_q == ST_DEEP && state_d == ST_WAKE) begin
        wakeIrq_q <= irqPending & ~wdtOverflow;
        phase_q <= 2'h0;
      end else if (state_q == ST_WAKE && dlyDone && !dlyLoad) begin
        phase_q <= phase_q;
      end else if (dlyLoad) begin
        phase_q <= 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset-control register: hardware set wins over software write
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin : rcProc
    reg [15:0] rcNext;
    if (!rst_b) begin
      resetControlReg <= 16'h0001;
    end else begin
      rcNext = resetControlReg;
      if (rcWrite) begin
        rcNext = rcWriteData & `WLP_RC_MASK;
      end
      if (porEvent) begin
        rcNext = 16'h0001;
      end else begin
        if (extResetEvent || swResetEvent) begin
          if (state_q == ST_DEEP || state_q == ST_WAKE ||
              state_q == ST_HOLD) begin
            rcNext[`WLP_RC_SLEEP] = 1'b1;
          end
          if (state_q == ST_CORE) begin
            rcNext[`WLP_RC_IDLE] = 1'b1;
          end
          rcNext[`WLP_RC_EXTR] = extResetEvent;
          rcNext[`WLP_RC_SWR] = swResetEvent;
        end else if (state_q == ST_DEEP && (irqPending || wdtOverflow)) begin
          rcNext[`WLP_RC_SLEEP] = 1'b1;
          if (wdtOverflow) begin
            rcNext[`WLP_RC_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
          end
        end else if (state_q == ST_CORE && (irqPending || wdtOverflow)) begin
          rcNext[`WLP_RC_IDLE] = 1'b1;
          if (wdtOverflow) begin
            rcNext[`WLP_RC_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
          end
        end else if (state_q == ST_RUN && wdtOverflow) begin
          rcNext[`WLP_RC_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        end
      end
      resetControlReg <= rcNext;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs: clock gating, resets, traps, table reads
  // ----------------------------------------------------------------
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cpuClockEn <= 1'b1;
      periphClockEn <= {NUM_PERIPH{1'b1}};
      oscEnable <= 1'b1;
      slowRcEnable <= 1'b0;
      failSafeActive <= 1'b0;
      wdtResetReq <= 1'b0;
      irqVectorTake <= 1'b0;
      clockFailTrap <= 1'b0;
      fastRcForce <= 1'b0;
      tableReadData <= 24'h000000;
    end else begin
      cpuClockEn <= (state_d == ST_RUN);
      case (state_d)
        ST_DEEP, ST_WAKE, ST_HOLD: begin
          periphClockEn <= {NUM_PERIPH{1'b0}};
        end
        ST_CORE: begin
          periphClockEn <= periphIdleRun;
        end
        default: begin
          periphClockEn <= {NUM_PERIPH{1'b1}};
        end
      endcase
      oscEnable <= (state_d != ST_DEEP);
      slowRcEnable <= wdtEnable | (failSafeEnable &&
                      state_d != ST_DEEP);
      failSafeActive <= failSafeEnable && state_d != ST_DEEP;
      wdtResetReq <= wdtOverflow && state_q == ST_RUN;
      irqVectorTake <= ((state_q == ST_WAKE || state_q == ST_HOLD) &&
                        state_d == ST_RUN && wakeIrq_q && !anyReset) ||
                       (state_q == ST_CORE && irqPending &&
                        !wdtOverflow && !anyReset);
      clockFailTrap <= state_q == ST_WAKE && dlyDone &&
                       state_d == ST_RUN && failSafeEnable &&
                       !oscRunning;
      if (clockFailTrap) begin
        fastRcForce <= 1'b1;
      end else if (anyReset) begin
        fastRcForce <= 1'b0;
      end
      if (tableReadStrobe) begin
        case (tableReadAddr)
          `WLP_OSC_CFG_ADDR: tableReadData <= {8'h00, oscConfigWord[15:0]};
          `WLP_WDT_CFG_ADDR: tableReadData <= {8'h00, wdtConfigWord[15:0]};
          `WLP_SEG_CFG_ADDR: tableReadData <= {8'h00, segConfigWord[15:0]};
          default: tableReadData <= 24'h000000;
        endcase
      end
    end
  end

endmodule

// ### dv/wlp_power_ctrl_asserts.sv
// Checker for the watchdog and low-power control block
`timescale 1ns/1ps
`include "wlp_defs.vh"
module wlp_power_ctrl_asserts #(
  parameter NUM_PERIPH = 8
) (
  input logic clock,
  input logic rst_b,
  input logic porEvent,
  input logic extResetEvent,
  input logic swResetEvent,
  input logic powerSaveInstr,
  input logic powerSaveMode,
  input logic irqPending,
  input logic [NUM_PERIPH-1:0] periphIdleRun,
  input logic tableReadStrobe,
  input logic [23:0] tableReadAddr,
  input logic [23:0] wdtConfigWord,
  input logic [23:0] tableReadData,
  input logic [15:0] resetControlReg,
  input logic cpuClockEn,
  input logic [NUM_PERIPH-1:0] periphClockEn,
  input logic oscEnable,
  input logic failSafeActive,
  input logic wdtResetReq,
  input logic irqVectorTake
);
  // ----------------------------------------
  // Common clocking and quiet condition
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire quiet = !porEvent && !extResetEvent && !swResetEvent;
  wire inIdle = !cpuClockEn && periphIdleRun != 0 &&
    periphClockEn == periphIdleRun;
  wire inDeep = !cpuClockEn && periphClockEn == 0;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  idle_entry_a: assert property (powerSaveInstr && powerSaveMode &&
    cpuClockEn && quiet && !irqPending |=> inIdle && oscEnable)
    else $error("core-only entry wrong");
  deep_entry_a: assert property (powerSaveInstr && !powerSaveMode &&
    cpuClockEn && quiet && !irqPending |=> inDeep)
    else $error("deep entry wrong");
  run_hold_a: assert property (cpuClockEn && !powerSaveInstr &&
    quiet |=> cpuClockEn) else $error("left run without instruction");
  monitor_off_a: assert property (!oscEnable |-> !failSafeActive)
    else $error("clock monitor active in deep state");
  idle_wake_a: assert property (inIdle && irqPending && quiet
    |=> cpuClockEn && irqVectorTake) else $error("core-only wake late");
  wake_bound_a: assert property (inDeep && irqPending
    |-> ##[1:300] cpuClockEn) else $error("deep wake missing");
  wdt_run_a: assert property (wdtResetReq |-> $past(cpuClockEn))
    else $error("watchdog reset outside run");
  table_word_a: assert property (tableReadStrobe &&
    tableReadAddr == `WLP_WDT_CFG_ADDR |=>
    tableReadData == {8'h00, $past(wdtConfigWord[15:0])})
    else $error("watchdog word read wrong");
  table_high_a: assert property (tableReadStrobe |=>
    tableReadData[23:16] == 8'h00) else $error("upper byte not zero");
  por_flags_a: assert property (porEvent |=>
    resetControlReg[3:2] == 2'b00 && resetControlReg[`WLP_RC_POR])
    else $error("power-on flags wrong");
  pin_sleep_a: assert property (extResetEvent && !porEvent && inDeep
    |=> resetControlReg[`WLP_RC_SLEEP]) else $error("sleep flag not set");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cover property (powerSaveInstr && powerSaveMode && cpuClockEn);
  cover property (inDeep && irqPending);
  cover property (wdtResetReq);
endmodule

bind wlp_power_ctrl wlp_power_ctrl_asserts #(.NUM_PERIPH(NUM_PERIPH)) u_chk (
  .clock, .rst_b, .porEvent, .extResetEvent, .swResetEvent,
  .powerSaveInstr, .powerSaveMode, .irqPending, .periphIdleRun,
  .tableReadStrobe, .tableReadAddr, .wdtConfigWord, .tableReadData,
  .resetControlReg, .cpuClockEn, .periphClockEn, .oscEnable,
  .failSafeActive, .wdtResetReq, .irqVectorTake
);

// ### dv/tb.sv
// Self-checking bench for the watchdog and low-power control block
`timescale 1ns/1ps
`include "wlp_defs.vh"
module tb;
  localparam PW = 5;
  localparam LK = 3;
  localparam [14:0] CODES = {`WLP_OSC_LP, `WLP_OSC_EC, `WLP_OSC_XTALPLL,
    `WLP_OSC_XTAL, `WLP_OSC_FRC};
  reg clock, rst_b, porEvent, extResetEvent, swResetEvent;
  reg tableReadStrobe, rcWrite, watchdogClearInstr, powerSaveInstr;
  reg powerSaveMode, slowRcTick, irqPending, pllInUse, lpCrystalKeepOn;
  reg oscRunning, failSafeEnable, sawRst, sawVec, sawTrap;
  reg clockSwitchEnable, oscStartupDone;
  reg [23:0] tableReadAddr, wdtCfg;
  reg [15:0] rcWriteData;
  reg [2:0] currentOscField;
  wire [23:0] tableReadData;
  wire [15:0] resetControlReg;
  wire [7:0] periphClockEn;
  wire [2:0] wakeOscSel;
  wire cpuClockEn, oscEnable, slowRcEnable, failSafeActive, wdtResetReq;
  wire irqVectorTake, clockFailTrap, fastRcForce;
  integer mismatches = 0;
  integer check_count = 0;
  integer i, n, e;

  // ----------------------------------------
  // Design, clock and pulse catchers
  // ----------------------------------------
  wlp_power_ctrl #(.WDT_WIDTH(4), .LOCK_CYC(LK), .POWER_UP_TIMER_CYC(PW))
    u_wlp_power_ctrl (.clock, .rst_b, .porEvent, .extResetEvent,
    .swResetEvent, .oscConfigWord(24'h12a5c3), .wdtConfigWord(wdtCfg),
    .segConfigWord(24'hab1234), .tableReadStrobe, .tableReadAddr,
    .tableReadData, .rcWrite, .rcWriteData, .resetControlReg,
    .watchdogClearInstr, .powerSaveInstr, .powerSaveMode, .slowRcTick,
    .irqPending, .currentOscField, .clockSwitchEnable, .pllInUse,
    .oscStartupDone, .pllLock(oscRunning), .lpCrystalKeepOn,
    .oscRunning, .failSafeEnable, .periphIdleRun(8'h5a), .cpuClockEn,
    .periphClockEn, .oscEnable, .wakeOscSel, .slowRcEnable,
    .failSafeActive, .wdtResetReq, .irqVectorTake, .clockFailTrap,
    .fastRcForce);
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  // Latch one-cycle pulses
  always @(posedge clock) begin
    if (wdtResetReq) sawRst = 1;
    if (irqVectorTake) sawVec = 1;
    if (clockFailTrap) sawTrap = 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task step(input integer k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task chk(input [23:0] s, input [23:0] x, input string nm);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task rd(input [23:0] a, input [23:0] x, input string nm);
    tableReadAddr = a;
    tableReadStrobe = 1;
    step(1);
    tableReadStrobe = 0;
    step(1);
    chk(tableReadData, x, nm);
  endtask
  task rcw(input [15:0] d);
    rcWriteData = d;
    rcWrite = 1;
    step(1);
    rcWrite = 0;
  endtask
  task ps(input m);
    powerSaveMode = m;
    powerSaveInstr = 1;
    step(1);
    powerSaveInstr = 0;
    step(2);
  endtask
  task tick(input integer k);
    repeat (k) begin
      slowRcTick = 1;
      step(1);
      slowRcTick = 0;
      step(1);
    end
  endtask
  task clr;
    watchdogClearInstr = 1;
    step(1);
    watchdogClearInstr = 0;
  endtask
  task irq;
    irqPending = 1;
    step(1);
    irqPending = 0;
  endtask
  task run_wait;
    n = 0;
    while (cpuClockEn !== 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
  endtask
  task wrap_up;
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog on hangs
  // ----------------------------------------
  initial begin
    #500000;
    mismatches++;
    wrap_up;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {porEvent, extResetEvent, swResetEvent, tableReadStrobe} = 0;
    {rcWrite, watchdogClearInstr, powerSaveInstr, powerSaveMode} = 0;
    {slowRcTick, irqPending, pllInUse, lpCrystalKeepOn} = 0;
    {sawRst, sawVec, sawTrap} = 0;
    {clockSwitchEnable, oscStartupDone} = 2'b11;
    oscRunning = 1;
    failSafeEnable = 1;
    rst_b = 0;
    tableReadAddr = 0;
    rcWriteData = 0;
    currentOscField = 0;
    wdtCfg = 24'hffff7f;
    step(5);
    rst_b = 1;
    step(1);
    chk(resetControlReg, 16'h0001, "rcReset");
    rd(`WLP_OSC_CFG_ADDR, 24'h00a5c3, "oscWord");
    rd(`WLP_WDT_CFG_ADDR, {8'h00, wdtCfg[15:0]}, "wdtWord");
    rd(`WLP_SEG_CFG_ADDR, 24'h001234, "segWord");
    rd(24'hf80004, 24'h000000, "noWord");
    // Software enable, clear and overflow
    tick(20);
    chk(sawRst, 0, "wdtOff");
    rcw(16'h0020);
    tick(10);
    clr;
    tick(15);
    chk(sawRst, 0, "wdtClr");
    tick(1);
    step(3);
    chk(sawRst, 1, "wdtOvf");
    chk(resetControlReg[`WLP_RC_WATCHDOG_TIMEOUT_FLAG], 1, "wdtoFlag");
    rcw(16'h0000);
    step(1);
    chk(resetControlReg, 16'h0000, "rcClear");
    wdtCfg = `WLP_CFG_ERASED;
    clr;
    sawRst = 0;
    tick(16);
    step(3);
    chk(sawRst, 1, "fuseOn");
    wdtCfg = 24'hffff7f;
    rcw(16'h0000);
    // Core-only state and interrupt wake
    ps(1);
    chk(cpuClockEn, 0, "idleCpu");
    chk(periphClockEn, 8'h5a, "idlePer");
    chk(oscEnable, 1, "idleOsc");
    chk(slowRcEnable, 1, "idleRc");
    sawVec = 0;
    irq;
    chk(cpuClockEn, 1, "idleWake");
    step(1);
    chk(sawVec, 1, "idleVec");
    chk(resetControlReg[`WLP_RC_IDLE], 1, "idleFlag");
    // Deep state, interrupt wake for five oscillator sources
    for (i = 0; i < 5; i++) begin
      currentOscField = CODES[i*3 +: 3];
      pllInUse = (currentOscField == `WLP_OSC_XTALPLL);
      lpCrystalKeepOn = (currentOscField == `WLP_OSC_LP);
      e = `WLP_POWER_ON_DELAY_CYC;
      if (currentOscField == `WLP_OSC_XTAL) e = e + PW;
      if (pllInUse) e = e + PW + LK;
      rcw(16'h0000);
      ps(0);
      chk(periphClockEn, 0, "deepPer");
      chk(failSafeActive, 0, "deepFsm");
      chk(slowRcEnable, 0, "deepRc");
      if (!lpCrystalKeepOn) chk(oscEnable, 0, "deepOsc");
      sawVec = 0;
      irq;
      run_wait;
      chk(n >= e && n <= e + 8, 1, "wakeDly");
      step(2);
      chk(sawVec, 1, "deepVec");
      chk(resetControlReg[`WLP_RC_SLEEP], 1, "deepFlag");
      chk(wakeOscSel, currentOscField, "wakeSrc");
    end
    // Watchdog wake from both states
    currentOscField = `WLP_OSC_FRC;
    pllInUse = 0;
    lpCrystalKeepOn = 0;
    for (i = 0; i < 2; i++) begin
      rcw(16'h0020);
      clr;
      ps(i[0]);
      if (i == 0) chk(slowRcEnable, 1, "deepWdtRc");
      sawRst = 0;
      tick(16);
      run_wait;
      chk(sawRst, 0, "wdtWake");
      chk(resetControlReg[`WLP_RC_WATCHDOG_TIMEOUT_FLAG], 1, "wakeWdto");
      chk(resetControlReg[i ? `WLP_RC_IDLE : `WLP_RC_SLEEP], 1,
        "wakeMode");
    end
    // Pin and software resets in low-power states, then power-on reset
    rcw(16'h0000);
    ps(0);
    extResetEvent = 1;
    step(1);
    extResetEvent = 0;
    step(1);
    chk(resetControlReg[`WLP_RC_EXTR], 1, "pinFlag");
    chk(resetControlReg[`WLP_RC_SLEEP], 1, "pinSleep");
    run_wait;
    chk(cpuClockEn, 1, "pinWake");
    rcw(16'h0000);
    ps(1);
    swResetEvent = 1;
    step(1);
    swResetEvent = 0;
    step(1);
    chk(resetControlReg[`WLP_RC_IDLE], 1, "swIdle");
    chk(cpuClockEn, 1, "swWake");
    porEvent = 1;
    step(1);
    porEvent = 0;
    step(1);
    chk(resetControlReg & 16'h000d, 16'h0001, "porFlags");
    // Fixed source from the configuration word, start-up timer late
    clockSwitchEnable = 0;
    oscStartupDone = 0;
    failSafeEnable = 0;
    pllInUse = 1;
    rcw(16'h0000);
    ps(0);
    chk(wakeOscSel, `WLP_OSC_XTALPLL, "fixedSrc");
    sawVec = 0;
    irq;
    step(260);
    chk(cpuClockEn, 0, "ostHold");
    oscStartupDone = 1;
    step(2);
    chk(cpuClockEn, 1, "ostDone");
    chk(sawVec, 1, "holdVec");
    {clockSwitchEnable, failSafeEnable} = 2'b11;
    pllInUse = 0;
    // Crystal dead after the wake delays
    currentOscField = `WLP_OSC_XTAL;
    rcw(16'h0000);
    ps(0);
    oscRunning = 0;
    sawTrap = 0;
    irq;
    step(260);
    chk(sawTrap, 1, "clkTrap");
    chk(fastRcForce, 1, "frcOn");
    wrap_up;
  end
endmodule
